// ==== hw/psc_stage.sv ====
// Programmable stage comparator: pick-up, blocking, delays, events,
// counters and operation log, with an APB register slave.
// Assumes meas, blk_in and time_stamp are synchronous to ref_clk.

module psc_stage import psc_pkg::*; #(
   parameter int PROG_CLKS = PROG_CYCLE_CLKS,
   parameter int LOG_N     = LOG_DEPTH
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   // APB slave
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Measurement, blocking and time base
   input  wire logic signed [DW-1:0] meas,
   input  wire logic                 blk_in,
   input  wire logic [DW-1:0]        time_stamp,
   // Stage status
   output psc_flags_t                flags_o,
   // Event stream
   output logic                      evt_valid,
   output psc_event_t                evt_o
);
   localparam int PW = $clog2(PROG_CLKS);
   localparam logic [PW-1:0] DIV_LAST = PW'(PROG_CLKS - 1);
   localparam int IW = $clog2(LOG_N);

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_REL} psc_state_t;

   logic [DW-1:0]        ctrl_reg;
   logic signed [DW-1:0] pickup_reg;
   logic [7:0]           hyst_reg;
   logic signed [DW-1:0] blklim_reg;
   logic [TW-1:0]        opdly_reg;
   logic [TW-1:0]        reldly_reg;
   logic [IW-1:0]        log_sel_reg;
   logic [PW-1:0]        div_reg;
   logic                 tick_reg;
   psc_state_t           state_reg;
   psc_flags_t           flags_reg;
   psc_flags_t           flags_d_reg;
   logic                 picked_reg;
   logic                 blk_smp_reg;
   logic [TW-1:0]        op_cnt_reg;
   logic [TW-1:0]        rel_cnt_reg;
   logic [DW-1:0]        cnt_start_reg;
   logic [DW-1:0]        cnt_trip_reg;
   logic [DW-1:0]        cnt_blk_reg;
   logic                 evt_valid_reg;
   psc_event_t           evt_reg;
   logic [31:0]          prdata_reg;
   logic                 err_reg;

   logic                 wr_en;
   logic                 setup;
   logic                 cnt_clr;
   psc_mode_t            mode;
   psc_flags_t           on_en;
   psc_flags_t           off_en;
   logic                 picked_next;
   logic [TW-1:0]        op_inc;
   logic [TW-1:0]        rel_inc;
   logic [TW-1:0]        remain;
   psc_flags_t           on_now;
   psc_flags_t           off_now;
   psc_rec_t             rec;
   psc_rec_t             log_rd;
   logic [IW:0]          log_cnt;
   logic [31:0]          rd_val;
   logic                 rd_err;

   function automatic logic signed [DW-1:0] ratio_f(
      input logic signed [DW-1:0] m,
      input logic signed [DW-1:0] p);
      longint q;
      q = (p == 0) ? 0 : (longint'(m) <<< RATIO_FRAC) / longint'(p);
      return DW'(q);
   endfunction

   assign wr_en   = psel && penable && pwrite;
   assign setup   = psel && !penable;
   assign cnt_clr = wr_en && paddr == A_CTRL && pwdata[C_CNT_CLR];
   assign mode    = psc_mode_t'(ctrl_reg[C_MODE_LSB +: 3]);
   assign on_en   = psc_flags_t'(ctrl_reg[C_ON_EN_LSB +: 3]);
   assign off_en  = psc_flags_t'(ctrl_reg[C_OFF_EN_LSB +: 3]);
   assign op_inc  = op_cnt_reg + TW'(1);
   assign rel_inc = rel_cnt_reg + TW'(1);
   assign remain  = (opdly_reg > op_cnt_reg) ? opdly_reg - op_cnt_reg : '0;

   // Program cycle divider
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (div_reg == DIV_LAST) begin
         div_reg  <= '0;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + PW'(1);
         tick_reg <= 1'b0;
      end
   end

   // Settings registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg    <= CTRL_RST;
         pickup_reg  <= PICKUP_RST;
         hyst_reg    <= HYST_RST;
         blklim_reg  <= BLKLIM_RST;
         opdly_reg   <= OPDLY_RST;
         reldly_reg  <= RELDLY_RST;
         log_sel_reg <= '0;
      end else if (wr_en) begin
         if (paddr == A_CTRL)
            ctrl_reg <= pwdata & ~(32'h1 << C_CNT_CLR);
         else if (paddr == A_PICKUP)
            pickup_reg <= pwdata;
         else if (paddr == A_HYST)
            hyst_reg <= pwdata[7:0];
         else if (paddr == A_BLKLIM)
            blklim_reg <= pwdata;
         else if (paddr == A_OPDLY)
            opdly_reg <= pwdata[TW-1:0];
         else if (paddr == A_RELDLY)
            reldly_reg <= pwdata[TW-1:0];
         else if (paddr == A_LOG_SEL)
            log_sel_reg <= pwdata[IW-1:0];
      end
   end

   psc_compare #(
      .W    (DW),
      .TAPS (DELTA_TAPS)
   ) u_cmp (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .tick       (tick_reg),
      .mode       (mode),
      .pickup     (pickup_reg),
      .hyst       (hyst_reg),
      .blk_lim    (blklim_reg),
      .blk_lim_en (ctrl_reg[C_BLKLIM_EN]),
      .meas       (meas),
      .picked     (picked_reg),
      .picked_o   (picked_next)
   );

   // Stage sequence, evaluated once per program cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg   <= ST_IDLE;
         flags_reg   <= '0;
         picked_reg  <= 1'b0;
         blk_smp_reg <= 1'b0;
         op_cnt_reg  <= '0;
         rel_cnt_reg <= '0;
      end else if (tick_reg) begin
         picked_reg        <= picked_next;
         blk_smp_reg       <= blk_in;
         flags_reg.blocked <= picked_next && blk_in;
         if (picked_next && !blk_in) begin
            state_reg       <= ST_RUN;
            flags_reg.start <= 1'b1;
            rel_cnt_reg     <= '0;
            if (op_cnt_reg != '1) op_cnt_reg <= op_inc;
            if (op_inc >= opdly_reg) flags_reg.trip <= 1'b1;
         end else if (state_reg != ST_IDLE) begin
            flags_reg.start <= 1'b0;
            if (rel_inc >= reldly_reg) begin
               state_reg      <= ST_IDLE;
               flags_reg.trip <= 1'b0;
               op_cnt_reg     <= '0;
               rel_cnt_reg    <= '0;
            end else begin
               state_reg   <= ST_REL;
               rel_cnt_reg <= rel_inc;
            end
         end
      end
   end

   assign on_now  = flags_reg & ~flags_d_reg;
   assign off_now = ~flags_reg & flags_d_reg;

   // On and off events with time stamp
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flags_d_reg   <= '0;
         evt_valid_reg <= 1'b0;
         evt_reg       <= '0;
      end else begin
         flags_d_reg   <= flags_reg;
         evt_valid_reg <= |(on_now & on_en) || |(off_now & off_en);
         evt_reg.stamp <= time_stamp;
         evt_reg.on    <= on_now & on_en;
         evt_reg.off   <= off_now & off_en;
      end
   end

   // Event counters; a clear in the cycle of a new event leaves a count of one
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_start_reg <= '0;
         cnt_trip_reg  <= '0;
         cnt_blk_reg   <= '0;
      end else begin
         cnt_start_reg <= (cnt_clr ? '0 : cnt_start_reg)
                          + DW'(on_now.start);
         cnt_trip_reg  <= (cnt_clr ? '0 : cnt_trip_reg) + DW'(on_now.trip);
         cnt_blk_reg   <= (cnt_clr ? '0 : cnt_blk_reg)
                          + DW'(on_now.blocked);
      end
   end

   assign rec.stamp  = time_stamp;
   assign rec.evt    = on_now;
   assign rec.mag    = meas;
   assign rec.ratio  = ratio_f(meas, pickup_reg);
   assign rec.remain = remain;
   assign rec.group  = ctrl_reg[C_GROUP_LSB +: 3];

   psc_history #(
      .DEPTH (LOG_N),
      .IW    (IW)
   ) u_log (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .wr      (|on_now),
      .wdata   (rec),
      .rd_age  (log_sel_reg),
      .rdata   (log_rd),
      .count   (log_cnt)
   );

   // Register read decode
   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      if (paddr == A_CTRL)
         rd_val = ctrl_reg;
      else if (paddr == A_PICKUP)
         rd_val = pickup_reg;
      else if (paddr == A_HYST)
         rd_val = {24'h0, hyst_reg};
      else if (paddr == A_BLKLIM)
         rd_val = blklim_reg;
      else if (paddr == A_OPDLY)
         rd_val = 32'(opdly_reg);
      else if (paddr == A_RELDLY)
         rd_val = 32'(reldly_reg);
      else if (paddr == A_STATUS) begin
         rd_val[2:0]                 = flags_reg;
         rd_val[S_BLK_SMP]           = blk_smp_reg;
         rd_val[S_PICKED]            = picked_reg;
         rd_val[S_REMAIN_LSB +: TW]  = remain;
      end else if (paddr == A_CNT_START)
         rd_val = cnt_start_reg;
      else if (paddr == A_CNT_TRIP)
         rd_val = cnt_trip_reg;
      else if (paddr == A_CNT_BLK)
         rd_val = cnt_blk_reg;
      else if (paddr == A_LOG_SEL) begin
         rd_val[IW-1:0]            = log_sel_reg;
         rd_val[L_CNT_LSB +: IW+1] = log_cnt;
      end else if (paddr == A_LOG_STAMP)
         rd_val = log_rd.stamp;
      else if (paddr == A_LOG_MAG)
         rd_val = log_rd.mag;
      else if (paddr == A_LOG_RATIO)
         rd_val = log_rd.ratio;
      else if (paddr == A_LOG_INFO) begin
         rd_val[2:0]                = log_rd.evt;
         rd_val[L_GROUP_LSB +: 3]   = log_rd.group;
         rd_val[S_REMAIN_LSB +: TW] = log_rd.remain;
      end else
         rd_err = 1'b1;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_reg <= '0;
         err_reg    <= 1'b0;
      end else if (setup) begin
         prdata_reg <= pwrite ? '0 : rd_val;
         err_reg    <= rd_err;
      end
   end

   assign prdata    = prdata_reg;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && err_reg;
   assign flags_o   = flags_reg;
   assign evt_valid = evt_valid_reg;
   assign evt_o     = evt_reg;

   trip_tick_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(flags_reg.trip) |-> $past(tick_reg) && op_cnt_reg >= opdly_reg)
      else $error("trip rose off tick or early");
   start_free_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tick_reg && picked_next && !blk_in) |=> flags_reg.start)
      else $error("start missing on unblocked pick-up");
   blk_pick_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tick_reg && picked_next && blk_in) |=>
         flags_reg.blocked && !flags_reg.start)
      else $error("blocked pick-up handled wrong");
   rel_nostart_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_reg == ST_REL |-> !flags_reg.start)
      else $error("start held during release");
   blk_sample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !tick_reg |=> blk_smp_reg == $past(blk_smp_reg))
      else $error("blocking sampled off tick");
   evt_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ($rose(flags_reg.start) && on_en.start) |=>
         evt_valid && evt_o.on.start)
      else $error("start on event missing");
   evt_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ($fell(flags_reg.trip) && !off_en.trip) |=> !evt_o.off.trip)
      else $error("masked trip off event sent");
   cnt_trip_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ($rose(flags_reg.trip) && !cnt_clr) |=>
         cnt_trip_reg == $past(cnt_trip_reg) + 32'h1)
      else $error("trip counter did not advance");
endmodule

// ==== hw/psc_pkg.sv ====
// Shared constants, register map and carrier types of the stage comparator.
// Assumes a 200 MHz ref_clk and a 5 ms program cycle.
package psc_pkg;
   localparam int DW              = 32;
   localparam int TW              = 20;
   localparam int CLK_PERIOD_NS   = 5;
   localparam int PROG_CYCLE_MS   = 5;
   localparam int PROG_CYCLE_CLKS = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DELTA_WIN_MS    = 20;
   localparam int DELTA_TAPS      = DELTA_WIN_MS / PROG_CYCLE_MS;
   localparam int OPDLY_MS        = 40;
   localparam int RELDLY_MS       = 60;
   localparam int PCT_FULL        = 100;
   localparam int RATIO_FRAC      = 8;
   localparam int LOG_DEPTH       = 12;
   // Delays are counted in program cycles
   localparam logic [TW-1:0] OPDLY_RST  = TW'(OPDLY_MS / PROG_CYCLE_MS);
   localparam logic [TW-1:0] RELDLY_RST = TW'(RELDLY_MS / PROG_CYCLE_MS);
   localparam logic [7:0]    HYST_RST   = 8'h03;
   // Levels are in units of 0.0001; reset pick-up is 0.01
   localparam logic [DW-1:0] PICKUP_RST = 32'h0000_0064;
   localparam logic [DW-1:0] BLKLIM_RST = 32'h0000_0000;
   localparam logic [DW-1:0] CTRL_RST   = 32'h0000_7700;
   // Register byte offsets
   localparam logic [7:0] A_CTRL      = 8'h00;
   localparam logic [7:0] A_PICKUP    = 8'h04;
   localparam logic [7:0] A_HYST      = 8'h08;
   localparam logic [7:0] A_BLKLIM    = 8'h0C;
   localparam logic [7:0] A_OPDLY     = 8'h10;
   localparam logic [7:0] A_RELDLY    = 8'h14;
   localparam logic [7:0] A_STATUS    = 8'h18;
   localparam logic [7:0] A_CNT_START = 8'h1C;
   localparam logic [7:0] A_CNT_TRIP  = 8'h20;
   localparam logic [7:0] A_CNT_BLK   = 8'h24;
   localparam logic [7:0] A_LOG_SEL   = 8'h28;
   localparam logic [7:0] A_LOG_STAMP = 8'h2C;
   localparam logic [7:0] A_LOG_MAG   = 8'h30;
   localparam logic [7:0] A_LOG_RATIO = 8'h34;
   localparam logic [7:0] A_LOG_INFO  = 8'h38;
   // Field positions
   localparam int C_MODE_LSB   = 0;
   localparam int C_BLKLIM_EN  = 3;
   localparam int C_CNT_CLR    = 4;
   localparam int C_ON_EN_LSB  = 8;
   localparam int C_OFF_EN_LSB = 12;
   localparam int C_GROUP_LSB  = 16;
   localparam int S_BLK_SMP    = 3;
   localparam int S_PICKED     = 4;
   localparam int S_REMAIN_LSB = 12;
   localparam int L_CNT_LSB    = 8;
   localparam int L_GROUP_LSB  = 4;

   typedef enum logic [2:0] {
      M_OVER, M_OVER_ABS, M_UNDER, M_UNDER_ABS,
      M_DREL_S, M_DREL_A, M_DVAL_S, M_DVAL_A
   } psc_mode_t;

   typedef struct packed {
      logic blocked;
      logic trip;
      logic start;
   } psc_flags_t;

   typedef struct packed {
      logic [DW-1:0] stamp;
      psc_flags_t    on;
      psc_flags_t    off;
   } psc_event_t;

   typedef struct packed {
      logic [DW-1:0]        stamp;
      psc_flags_t           evt;
      logic signed [DW-1:0] mag;
      logic signed [DW-1:0] ratio;
      logic [TW-1:0]        remain;
      logic [2:0]           group;
   } psc_rec_t;
endpackage

// ==== hw/psc_compare.sv ====
// Pick-up comparator with hysteresis and a 20 ms delay line.
// Assumes tick is a one-cycle pulse once per program cycle.
module psc_compare import psc_pkg::*; #(
   parameter int W    = DW,
   parameter int TAPS = DELTA_TAPS
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                tick,
   // Settings
   input  wire psc_mode_t           mode,
   input  wire logic signed [W-1:0] pickup,
   input  wire logic [7:0]          hyst,
   input  wire logic signed [W-1:0] blk_lim,
   input  wire logic                blk_lim_en,
   // Measurement and held pick-up state
   input  wire logic signed [W-1:0] meas,
   input  wire logic                picked,
   output logic                     picked_o
);
   localparam int FW = $clog2(TAPS + 1);
   localparam logic [FW-1:0] FULL = FW'(TAPS);

   logic signed [W-1:0] line_reg [TAPS];
   logic [FW-1:0]       fill_reg;
   logic                full;

   function automatic longint mag_f(input longint x);
      return (x < 0) ? -x : x;
   endfunction

   function automatic longint pct_f(input longint x, input longint p);
      return x * p / PCT_FULL;
   endfunction

   assign full = (fill_reg == FULL);

   // Value from one delta window ago
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fill_reg <= '0;
         for (int i = 0; i < TAPS; i++) line_reg[i] <= '0;
      end else if (tick) begin
         line_reg[0] <= meas;
         for (int i = 1; i < TAPS; i++) line_reg[i] <= line_reg[i-1];
         if (!full) fill_reg <= fill_reg + FW'(1);
      end
   end

   always_comb begin
      longint m;
      longint p;
      longint prev;
      longint d;
      longint marg;
      longint thr;
      longint lvl;
      m    = longint'(meas);
      p    = longint'(pickup);
      prev = longint'(line_reg[TAPS-1]);
      d    = m - prev;
      marg = pct_f(mag_f(p), longint'(hyst));
      thr  = 0;
      lvl  = 0;
      picked_o = 1'b0;
      case (mode)
         M_OVER: picked_o = m > (picked ? p - marg : p);
         M_OVER_ABS: picked_o = mag_f(m) > (picked ? p - marg : p);
         M_UNDER: picked_o = (m < (picked ? p + marg : p))
            && !(blk_lim_en && m < longint'(blk_lim));
         M_UNDER_ABS: picked_o = (mag_f(m) < (picked ? p + marg : p))
            && !(blk_lim_en && m < longint'(blk_lim));
         default: begin
            if (mode == M_DREL_S || mode == M_DREL_A)
               thr = pct_f(mag_f(prev), mag_f(p));
            else
               thr = mag_f(p);
            if (picked) thr = thr - pct_f(thr, longint'(hyst));
            if (mode == M_DREL_A || mode == M_DVAL_A)
               lvl = mag_f(d);
            else
               lvl = (p < 0) ? -d : d;
            picked_o = full && (lvl > thr);
         end
      endcase
   end

   over_cmp_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode == M_OVER && !picked) |-> (picked_o == (meas > pickup)))
      else $error("over mode compare wrong");
   abs_over_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode == M_OVER_ABS && !picked && meas < 0 && -meas > pickup
       && pickup >= 0) |-> picked_o)
      else $error("absolute over mode missed");
   under_blk_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode == M_UNDER && blk_lim_en && meas < blk_lim) |-> !picked_o)
      else $error("under mode not suppressed by limit");
   delta_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode >= M_DREL_S && !full) |-> !picked_o)
      else $error("delta mode picked before window filled");
endmodule

// ==== hw/psc_history.sv ====
// Ring of the most recent operation records, read by age.
// Assumes wr is a one-cycle pulse; age 0 is the newest record.
module psc_history import psc_pkg::*; #(
   parameter int DEPTH = LOG_DEPTH,
   parameter int IW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   // Write side
   input  wire logic          wr,
   input  wire psc_rec_t      wdata,
   // Read side
   input  wire logic [IW-1:0] rd_age,
   output psc_rec_t           rdata,
   output logic [IW:0]        count
);
   localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
   localparam logic [IW:0]   CMAX = (IW+1)'(DEPTH);

   psc_rec_t      mem_reg [DEPTH];
   logic [IW-1:0] wptr_reg;
   logic [IW:0]   count_reg;

   function automatic logic [IW-1:0] idx_f(input logic [IW-1:0] ptr,
                                           input logic [IW-1:0] age);
      int s;
      s = int'(ptr) - 1 - int'(age);
      if (s < 0) s = s + DEPTH;
      return IW'(s);
   endfunction

   // Oldest entry is overwritten once all are used
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wptr_reg  <= '0;
         count_reg <= '0;
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
      end else if (wr) begin
         mem_reg[wptr_reg] <= wdata;
         wptr_reg <= (wptr_reg == LAST) ? '0 : wptr_reg + IW'(1);
         if (count_reg != CMAX) count_reg <= count_reg + (IW+1)'(1);
      end
   end

   assign rdata = ((IW+1)'(rd_age) < count_reg) ?
                  mem_reg[idx_f(wptr_reg, rd_age)] : '0;
   assign count = count_reg;

   hist_cnt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr && count_reg < CMAX) |=> count_reg == $past(count_reg) + 1'b1)
      else $error("history count did not advance");
   hist_newest_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr && rd_age == '0) ##1 (rd_age == '0) |->
         rdata == $past(wdata))
      else $error("newest record not at age zero");
endmodule

// ==== tb/psc_src_model.sv ====
// Partner model: measurement channel and blocking matrix of the device.
// Assumes requests change just after a rising edge of ref_clk.
module psc_src_model import psc_pkg::*; (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   // Requested levels
   input  wire logic signed [DW-1:0] m_req,
   input  wire logic                 b_req,
   // Toward the stage
   output logic signed [DW-1:0]      meas,
   output logic                      blk_in,
   output logic [DW-1:0]             time_stamp
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meas       <= '0;
         blk_in     <= 1'b0;
         time_stamp <= '0;
      end else begin
         meas       <= m_req;
         blk_in     <= b_req;
         time_stamp <= time_stamp + 32'h1;
      end
   end
endmodule

// ==== tb/psc_stage_tb.sv ====
// Self-checking bench of the stage: APB master and a behavioural model.
// Assumes the stage answers APB with zero waits and ticks every P clocks.
module psc_stage_tb import psc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 16;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, evt_valid;
   logic b_req, blk_in, serr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r, ts;
   logic signed [DW-1:0] meas, m_req;
   psc_flags_t flags, fl_d;
   psc_event_t ev, last_ev;
   logic [31:0] blk_ts;
   int n_errors, checks_done, cyc, seed, md, p, m, i;
   psc_src_model src (.ref_clk(ref_clk), .nrst(nrst), .m_req(m_req),
      .b_req(b_req), .meas(meas), .blk_in(blk_in), .time_stamp(ts));
   psc_stage #(.PROG_CLKS(P)) dut (.ref_clk(ref_clk), .nrst(nrst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas(meas), .blk_in(blk_in), .time_stamp(ts), .flags_o(flags),
      .evt_valid(evt_valid), .evt_o(ev));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= nrst ? cyc + 1 : 0;
   // Last event seen and stamp of the cycle in which blocked rose
   always @(posedge ref_clk) begin
      fl_d <= flags;
      if (evt_valid) last_ev <= ev;
      if (flags.blocked && !fl_d.blocked) blk_ts <= ts;
   end
   task give_verdict;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %0t seen %h want %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         n_errors++;
         give_verdict;
      end
   endtask
   task tk(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         while (cyc % P != P / 2) @(posedge ref_clk);
      end
   endtask
   function automatic logic pk(int md, int m, int p);
      case (md)
         0: return m > p;
         1: return (m < 0 ? -m : m) > p;
         2: return m < p;
         default: return (m < 0 ? -m : m) < p;
      endcase
   endfunction
   initial begin
      {nrst, psel, penable, pwrite, b_req, paddr, pwdata, m_req} = '0;
      seed = 32'h56DE10DC;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      apb(0, A_CTRL, 0);
      chk(r, CTRL_RST);
      apb(0, A_HYST, 0);
      chk(r, 32'h3);
      apb(0, 8'h3C, 0);
      chk({31'h0, serr}, 32'h1);
      for (i = 0; i < 16; i++) begin
         md = $random(seed) & 3;
         p = i[0] ? 1000 : -1000;
         m = ($random(seed) & 1) ? 2000 + ($random(seed) & 8191)
                                 : ($random(seed) & 511);
         if ($random(seed) & 1) m = -m;
         apb(1, A_CTRL, CTRL_RST | 32'(md));
         apb(1, A_PICKUP, 32'(p));
         m_req <= m;
         tk(2);
         apb(0, A_STATUS, 0);
         chk(32'(r[S_PICKED]), 32'(pk(md, m, p)));
      end
      apb(1, A_BLKLIM, -32'sd5000);
      apb(1, A_CTRL, CTRL_RST | 32'hA);
      m_req <= -8000;
      tk(2);
      apb(0, A_STATUS, 0);
      chk(32'(r[S_PICKED]), 32'h0);
      apb(1, A_CTRL, CTRL_RST);
      apb(1, A_OPDLY, 3);
      apb(1, A_RELDLY, 2);
      m_req <= 0;
      tk(14);
      apb(1, A_CTRL, CTRL_RST | 32'h10);
      m_req <= 5000;
      tk(2);
      chk(32'(flags), 32'h1);
      tk(1);
      chk(32'(flags), 32'h3);
      m_req <= 0;
      tk(1);
      chk(32'(flags), 32'h2);
      tk(2);
      chk(32'(flags), 32'h0);
      m_req <= 5000;
      tk(1);
      chk(32'(flags), 32'h1);
      b_req <= 1'b1;
      tk(1);
      chk(32'(flags), 32'h4);
      chk(32'(last_ev.on), 32'h4);
      chk(32'(last_ev.off), 32'h1);
      chk(last_ev.stamp, blk_ts);
      b_req <= 1'b0;
      m_req <= 0;
      tk(3);
      apb(0, A_CNT_START, 0);
      chk(r, 32'h2);
      apb(0, A_CNT_TRIP, 0);
      chk(r, 32'h1);
      apb(0, A_CNT_BLK, 0);
      chk(r, 32'h1);
      // Newest record is the blocked on event: 5000 against 1000, 2 left
      apb(0, A_LOG_STAMP, 0);
      chk(r, blk_ts);
      apb(0, A_LOG_MAG, 0);
      chk(r, 32'd5000);
      apb(0, A_LOG_RATIO, 0);
      chk(r, 32'd1280);
      apb(0, A_LOG_INFO, 0);
      chk(r, 32'h2004);
      // Change modes against the value four ticks back
      apb(1, A_CTRL, CTRL_RST | 32'h7);
      m_req <= 5000;
      tk(2);
      apb(0, A_STATUS, 0);
      chk(32'(r[S_PICKED]), 32'h1);
      tk(5);
      apb(0, A_STATUS, 0);
      chk(32'(r[S_PICKED]), 32'h0);
      apb(1, A_PICKUP, 32'd10);
      apb(1, A_CTRL, CTRL_RST | 32'h4);
      m_req <= 3000;
      tk(2);
      apb(0, A_STATUS, 0);
      chk(32'(r[S_PICKED]), 32'h0);
      apb(1, A_CTRL, CTRL_RST | 32'h5);
      tk(1);
      apb(0, A_STATUS, 0);
      chk(32'(r[S_PICKED]), 32'h1);
      tk(5);
      apb(1, A_PICKUP, -32'sd1000);
      apb(1, A_CTRL, CTRL_RST | 32'h6);
      m_req <= 0;
      tk(2);
      apb(0, A_STATUS, 0);
      chk(32'(r[S_PICKED]), 32'h1);
      give_verdict;
   end
   initial begin
      #200000;
      n_errors++;
      give_verdict;
   end
endmodule
